// ---- rtl/pixel_expand.sv ----
// widens any source pixel to 10 bits per component
module pixel_expand (
  // source side
  input wire logic [3:0] fmt_i,
  input wire logic [63:0] pixel_i,
  input wire logic [29:0] palette_rgb_i,
  // widened components
  output logic [9:0] red_o,
  output logic [9:0] green_o,
  output logic [9:0] blue_o
);

  // replicate msbs so full scale maps to full scale
  function automatic logic [9:0] widen8(input logic [7:0] c);
    widen8 = {c, c[7:6]};
  endfunction

  function automatic logic [9:0] widen6(input logic [5:0] c);
    widen6 = {c, c[5:2]};
  endfunction

  function automatic logic [9:0] widen5(input logic [4:0] c);
    widen5 = {c, c[4:0]};
  endfunction

  // clamps to [0,1]; values above one saturate, negatives go to zero
  function automatic logic [9:0] fp16_to_10(input logic [15:0] h);
    logic [4:0] shift;
    logic [10:0] mant;
    shift = 5'h00;
    mant = {1'b1, h[9:0]};
    if (h[15]) begin
      fp16_to_10 = 10'h000;
    end else if (h[14:10] >= plane_ctl_pkg::FP16_BIAS) begin
      fp16_to_10 = 10'h3FF;
    end else begin
      shift = plane_ctl_pkg::FP16_BIAS - h[14:10];
      mant = mant >> shift;
      fp16_to_10 = mant[9:0];
    end
  endfunction

  // format decode of the component layout
  always_comb begin
    red_o = 10'h000;
    green_o = 10'h000;
    blue_o = 10'h000;
    unique case (fmt_i)
      plane_ctl_pkg::FMT_INDEXED: begin
        red_o = palette_rgb_i[29:20];
        green_o = palette_rgb_i[19:10];
        blue_o = palette_rgb_i[9:0];
      end
      plane_ctl_pkg::FMT_BGRX565: begin
        red_o = widen5(pixel_i[15:11]);
        green_o = widen6(pixel_i[10:5]);
        blue_o = widen5(pixel_i[4:0]);
      end
      plane_ctl_pkg::FMT_BGRX8, plane_ctl_pkg::FMT_BGRA8: begin
        red_o = widen8(pixel_i[23:16]);
        green_o = widen8(pixel_i[15:8]);
        blue_o = widen8(pixel_i[7:0]);
      end
      plane_ctl_pkg::FMT_RGBX10, plane_ctl_pkg::FMT_RGBA10: begin
        red_o = pixel_i[9:0];
        green_o = pixel_i[19:10];
        blue_o = pixel_i[29:20];
      end
      plane_ctl_pkg::FMT_BGRX10, plane_ctl_pkg::FMT_BGRA10: begin
        red_o = pixel_i[29:20];
        green_o = pixel_i[19:10];
        blue_o = pixel_i[9:0];
      end
      plane_ctl_pkg::FMT_FP16X, plane_ctl_pkg::FMT_FP16A: begin
        red_o = fp16_to_10(pixel_i[15:0]);
        green_o = fp16_to_10(pixel_i[31:16]);
        blue_o = fp16_to_10(pixel_i[47:32]);
      end
      plane_ctl_pkg::FMT_RGBX8, plane_ctl_pkg::FMT_RGBA8: begin
        red_o = widen8(pixel_i[7:0]);
        green_o = widen8(pixel_i[15:8]);
        blue_o = widen8(pixel_i[23:16]);
      end
      default: begin
        // reserved codes give black
        red_o = 10'h000;
      end
    endcase
  end

endmodule

// ---- rtl/plane_ctl_pkg.sv ----
package plane_ctl_pkg;

  // register byte addresses within the display space
  localparam logic [19:0] CTRL_OFFSET = 20'h70180;
  localparam logic [19:0] LINOFF_OFFSET = 20'h70184;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] LINOFF_RESET = 32'h00000000;
  localparam logic [31:0] SURF_RESET = 32'h00000000;

  // control register field positions
  localparam int ENABLE_BIT = 31;
  localparam int GAMMA_BIT = 30;
  localparam int FMT_HI = 29;
  localparam int FMT_LO = 26;
  localparam int KEY_WIN_BIT = 23;
  localparam int KEY_EN_BIT = 22;
  localparam int MUL_HI = 21;
  localparam int MUL_LO = 20;
  localparam int ROT_BIT = 15;
  localparam int TRICKLE_BIT = 14;
  localparam int PART_BIT = 13;
  localparam int TILED_BIT = 10;
  localparam int ASYNC_BIT = 9;

  // surface word fields
  localparam int FLIP_SRC_BIT = 3;
  localparam logic [31:0] SURF_ADDR_MASK = 32'hFFFFF000;

  // source pixel format codes
  localparam logic [3:0] FMT_INDEXED = 4'h2;
  localparam logic [3:0] FMT_BGRX565 = 4'h5;
  localparam logic [3:0] FMT_BGRX8 = 4'h6;
  localparam logic [3:0] FMT_BGRA8 = 4'h7;
  localparam logic [3:0] FMT_RGBX10 = 4'h8;
  localparam logic [3:0] FMT_RGBA10 = 4'h9;
  localparam logic [3:0] FMT_BGRX10 = 4'hA;
  localparam logic [3:0] FMT_BGRA10 = 4'hB;
  localparam logic [3:0] FMT_FP16X = 4'hC;
  localparam logic [3:0] FMT_FP16A = 4'hD;
  localparam logic [3:0] FMT_RGBX8 = 4'hE;
  localparam logic [3:0] FMT_RGBA8 = 4'hF;

  // pixel multiply codes
  localparam logic [1:0] MUL_NONE = 2'h0;
  localparam logic [1:0] MUL_LINE_PIXEL = 2'h1;
  localparam logic [1:0] MUL_PIXEL = 2'h3;

  // x-tile geometry: 512 bytes by 8 rows, 4 KiB per tile
  localparam int TILE_ROWS_LOG2 = 3;
  localparam int TILE_WIDTH_LOG2 = 9;
  localparam int TILE_BYTES_LOG2 = 12;
  localparam logic [31:0] TILE_ROW_MASK = 32'h00000007;
  localparam logic [31:0] TILE_COL_MASK = 32'h000001FF;

  // half float exponent bias
  localparam logic [4:0] FP16_BIAS = 5'hF;

  // surface address update sequencing
  typedef enum logic [1:0] {SURF_IDLE, SURF_WAIT_SYNC, SURF_WAIT_ASYNC} surf_state_t;

endpackage

// ---- rtl/primary_plane_control.sv ----
// Functional notes
// - writes pend; trigger then vblank copies all together
// - pipe disabled: written values apply at once
// - enable generates pixels; clear blanks at vblank
// - gamma bit zero bypasses gamma correction
// - decode indexed, 565, 8888 and 10:10:10:2 formats
// - decode half float, rgb 8888; others reserved
// - every format widened to 10 bits per component
// - key window limits key to overlap area
// - key lets lower plane show on match
// - decode multiply: none, line+pixel, reserved, pixel
// - rotation bit presents plane turned 180 degrees
// - trickle zero: fetch whenever buffer has space
// - partition bit zero shares sprite space, ignored deep mode
// - tiled bit selects linear or x-tiled surface
// - tiled bit steers first pixel address math
// - async mmio surface write applies at lookup/vblank
// - default surface writes apply at vblank start
// - flip done routed by flip source bit
// - deep buffer mode freezes enable, even with the pipe disabled
// - tiled selection sits at control bit 10
module primary_plane_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [19:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // surface base writes from the neighbouring register
  input wire logic surf_wr_i,
  input wire logic surf_mmio_i,
  input wire logic [31:0] surf_wdata_i,
  // pipe timing
  input wire logic pipe_enabled_i,
  input wire logic vblank_start_i,
  input wire logic in_vblank_i,
  input wire logic tlb_req_i,
  // buffer and power state
  input wire logic max_fifo_mode_i,
  input wire logic sprite_enabled_i,
  input wire logic buf_free_i,
  input wire logic buf_free_block_i,
  // keying inputs
  input wire logic key_match_i,
  input wire logic in_overlap_i,
  // first pixel address inputs
  input wire logic [11:0] tile_x_i,
  input wire logic [11:0] tile_y_i,
  input wire logic [31:0] pitch_i,
  // pixel stream
  input wire logic pixel_valid_i,
  input wire logic [63:0] pixel_i,
  input wire logic [29:0] palette_rgb_i,
  // plane state
  output logic plane_on_o,
  output logic blank_o,
  output logic fetch_req_o,
  output logic gamma_bypass_o,
  output logic rotate_o,
  output logic tiled_o,
  output logic use_sprite_space_o,
  output logic show_below_o,
  output logic line_double_o,
  output logic pixel_double_o,
  // format decode
  output logic fmt_indexed_o,
  output logic fmt_alpha_o,
  output logic fmt_float_o,
  output logic fmt_reserved_o,
  output logic [3:0] bytes_per_pixel_o,
  // surface
  output logic [31:0] surface_base_o,
  output logic [31:0] first_pixel_addr_o,
  output logic flip_done_render_o,
  output logic flip_done_blitter_o,
  // widened pixels
  output logic pix_valid_o,
  output logic [9:0] red_o,
  output logic [9:0] green_o,
  output logic [9:0] blue_o
);

  // pending and active control state
  logic [31:0] ctrl_pend_reg, ctrl_pend_next;
  logic [31:0] lin_pend_reg, lin_pend_next;
  logic [31:0] ctrl_act_reg, ctrl_act_next;
  logic [31:0] lin_act_reg, lin_act_next;
  logic armed_reg, armed_next;
  // surface update state
  plane_ctl_pkg::surf_state_t surf_state_reg, surf_state_next;
  logic [31:0] surf_pend_reg, surf_pend_next;
  logic [31:0] surf_act_reg, surf_act_next;
  logic flip_cs_reg, flip_cs_next;
  logic flip_bcs_reg, flip_bcs_next;
  // read port and datapath outputs
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] addr_reg, addr_next;
  logic pvalid_reg, pvalid_next;
  logic [29:0] rgb_reg, rgb_next;
  // decode helpers
  logic ctrl_wr, lin_wr, trigger, vb_apply, surf_apply;
  logic [3:0] fmt;
  logic [1:0] mul;
  logic [9:0] exp_r, exp_g, exp_b;
  logic [31:0] xbytes, tiled_off;

  assign ctrl_wr = reg_wr_i && (reg_addr_i == plane_ctl_pkg::CTRL_OFFSET);
  assign lin_wr = reg_wr_i && (reg_addr_i == plane_ctl_pkg::LINOFF_OFFSET);
  assign fmt = ctrl_act_reg[plane_ctl_pkg::FMT_HI:plane_ctl_pkg::FMT_LO];
  assign mul = ctrl_act_reg[plane_ctl_pkg::MUL_HI:plane_ctl_pkg::MUL_LO];

  // a surface write, or any change of enable, arms the vblank copy;
  // a falling enable also arms so that disabling lands at vblank
  assign trigger = surf_wr_i ||
    (ctrl_wr && (reg_wdata_i[plane_ctl_pkg::ENABLE_BIT] !=
                 ctrl_pend_reg[plane_ctl_pkg::ENABLE_BIT]));
  assign vb_apply = armed_reg && vblank_start_i;

  // control double buffer next state
  always_comb begin
    ctrl_pend_next = ctrl_wr ? reg_wdata_i : ctrl_pend_reg;
    lin_pend_next = lin_wr ? reg_wdata_i : lin_pend_reg;
    ctrl_act_next = ctrl_act_reg;
    lin_act_next = lin_act_reg;
    // a new trigger in the apply cycle re-arms rather than being lost
    armed_next = trigger || (armed_reg && !vb_apply);
    if (!pipe_enabled_i) begin
      // idle pipe: nothing to tear, follow writes directly
      ctrl_act_next = ctrl_pend_next;
      lin_act_next = lin_pend_next;
      armed_next = 1'b0;
    end else if (vb_apply) begin
      ctrl_act_next = ctrl_pend_reg;
      lin_act_next = lin_pend_reg;
    end
    // deep buffer mode keeps the enable frozen
    if (max_fifo_mode_i) begin
      ctrl_act_next[plane_ctl_pkg::ENABLE_BIT] =
        ctrl_act_reg[plane_ctl_pkg::ENABLE_BIT];
    end
  end

  // control double buffer registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_pend_reg <= plane_ctl_pkg::CTRL_RESET;
      lin_pend_reg <= plane_ctl_pkg::LINOFF_RESET;
      ctrl_act_reg <= plane_ctl_pkg::CTRL_RESET;
      lin_act_reg <= plane_ctl_pkg::LINOFF_RESET;
      armed_reg <= 1'b0;
    end else begin
      ctrl_pend_reg <= ctrl_pend_next;
      lin_pend_reg <= lin_pend_next;
      ctrl_act_reg <= ctrl_act_next;
      lin_act_reg <= lin_act_next;
      armed_reg <= armed_next;
    end
  end

  // surface update sequencing next state
  always_comb begin
    surf_state_next = surf_state_reg;
    surf_pend_next = surf_pend_reg;
    surf_act_next = surf_act_reg;
    surf_apply = 1'b0;
    unique case (surf_state_reg)
      plane_ctl_pkg::SURF_IDLE: surf_apply = 1'b0;
      plane_ctl_pkg::SURF_WAIT_SYNC: surf_apply = vblank_start_i;
      // a write seen inside vblank waits for the first active lookups
      plane_ctl_pkg::SURF_WAIT_ASYNC:
        surf_apply = (tlb_req_i && !in_vblank_i) || vblank_start_i;
    endcase
    if (!pipe_enabled_i && surf_state_reg != plane_ctl_pkg::SURF_IDLE) begin
      surf_apply = 1'b1;
    end
    if (surf_apply) begin
      surf_act_next = surf_pend_reg;
      surf_state_next = plane_ctl_pkg::SURF_IDLE;
    end
    // a later write replaces the pending one; async only for mmio writes
    // and never while pixel multiply is active
    if (surf_wr_i) begin
      surf_pend_next = surf_wdata_i;
      if (ctrl_act_reg[plane_ctl_pkg::ASYNC_BIT] && surf_mmio_i &&
          mul == plane_ctl_pkg::MUL_NONE) begin
        surf_state_next = plane_ctl_pkg::SURF_WAIT_ASYNC;
      end else begin
        surf_state_next = plane_ctl_pkg::SURF_WAIT_SYNC;
      end
    end
    // flip done follows the source of the applied surface
    flip_cs_next = surf_apply && !surf_pend_reg[plane_ctl_pkg::FLIP_SRC_BIT];
    flip_bcs_next = surf_apply && surf_pend_reg[plane_ctl_pkg::FLIP_SRC_BIT];
  end

  // surface update registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      surf_state_reg <= plane_ctl_pkg::SURF_IDLE;
      surf_pend_reg <= plane_ctl_pkg::SURF_RESET;
      surf_act_reg <= plane_ctl_pkg::SURF_RESET;
      flip_cs_reg <= 1'b0;
      flip_bcs_reg <= 1'b0;
    end else begin
      surf_state_reg <= surf_state_next;
      surf_pend_reg <= surf_pend_next;
      surf_act_reg <= surf_act_next;
      flip_cs_reg <= flip_cs_next;
      flip_bcs_reg <= flip_bcs_next;
    end
  end

  // format decode of the active copy
  always_comb begin
    fmt_indexed_o = 1'b0;
    fmt_alpha_o = 1'b0;
    fmt_float_o = 1'b0;
    fmt_reserved_o = 1'b0;
    bytes_per_pixel_o = 4'h4;
    unique case (fmt)
      plane_ctl_pkg::FMT_INDEXED: begin
        fmt_indexed_o = 1'b1;
        bytes_per_pixel_o = 4'h1;
      end
      plane_ctl_pkg::FMT_BGRX565: bytes_per_pixel_o = 4'h2;
      plane_ctl_pkg::FMT_BGRX8, plane_ctl_pkg::FMT_RGBX10, plane_ctl_pkg::FMT_BGRX10,
      plane_ctl_pkg::FMT_RGBX8: bytes_per_pixel_o = 4'h4;
      plane_ctl_pkg::FMT_BGRA8, plane_ctl_pkg::FMT_RGBA10, plane_ctl_pkg::FMT_BGRA10,
      plane_ctl_pkg::FMT_RGBA8: fmt_alpha_o = 1'b1;
      plane_ctl_pkg::FMT_FP16X: begin
        fmt_float_o = 1'b1;
        bytes_per_pixel_o = 4'h8;
      end
      plane_ctl_pkg::FMT_FP16A: begin
        fmt_float_o = 1'b1;
        fmt_alpha_o = 1'b1;
        bytes_per_pixel_o = 4'h8;
      end
      default: fmt_reserved_o = 1'b1;
    endcase
  end

  // plane state outputs; enable only counts with the pipe running
  assign plane_on_o = ctrl_act_reg[plane_ctl_pkg::ENABLE_BIT] && pipe_enabled_i;
  assign blank_o = !plane_on_o;
  assign fetch_req_o = plane_on_o && (ctrl_act_reg[plane_ctl_pkg::TRICKLE_BIT] ?
                       buf_free_block_i : buf_free_i);
  assign gamma_bypass_o = !ctrl_act_reg[plane_ctl_pkg::GAMMA_BIT];
  assign rotate_o = ctrl_act_reg[plane_ctl_pkg::ROT_BIT];
  assign tiled_o = ctrl_act_reg[plane_ctl_pkg::TILED_BIT];
  assign use_sprite_space_o = !ctrl_act_reg[plane_ctl_pkg::PART_BIT] &&
                              !sprite_enabled_i && !max_fifo_mode_i;
  // alpha formats never key, even if software sets the bit anyway
  assign show_below_o = plane_on_o && ctrl_act_reg[plane_ctl_pkg::KEY_EN_BIT] &&
    !fmt_alpha_o && key_match_i &&
    (!ctrl_act_reg[plane_ctl_pkg::KEY_WIN_BIT] || in_overlap_i);
  assign line_double_o = (mul == plane_ctl_pkg::MUL_LINE_PIXEL);
  assign pixel_double_o = (mul == plane_ctl_pkg::MUL_LINE_PIXEL) ||
                          (mul == plane_ctl_pkg::MUL_PIXEL);
  assign surface_base_o = surf_act_reg & plane_ctl_pkg::SURF_ADDR_MASK;
  assign flip_done_render_o = flip_cs_reg;
  assign flip_done_blitter_o = flip_bcs_reg;
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign first_pixel_addr_o = addr_reg;
  assign pix_valid_o = pvalid_reg;
  assign red_o = rgb_reg[29:20];
  assign green_o = rgb_reg[19:10];
  assign blue_o = rgb_reg[9:0];

  // component widening
  pixel_expand u_expand (
    .fmt_i(fmt),
    .pixel_i(pixel_i),
    .palette_rgb_i(palette_rgb_i),
    .red_o(exp_r),
    .green_o(exp_g),
    .blue_o(exp_b)
  );

  // x-tile offset: whole tile rows, whole tiles, then row and byte in tile
  assign xbytes = 32'(tile_x_i) * 32'(bytes_per_pixel_o);
  assign tiled_off = (((32'(tile_y_i) >> plane_ctl_pkg::TILE_ROWS_LOG2) * pitch_i)
                      << plane_ctl_pkg::TILE_ROWS_LOG2) +
                     ((xbytes >> plane_ctl_pkg::TILE_WIDTH_LOG2)
                      << plane_ctl_pkg::TILE_BYTES_LOG2) +
                     ((32'(tile_y_i) & plane_ctl_pkg::TILE_ROW_MASK)
                      << plane_ctl_pkg::TILE_WIDTH_LOG2) +
                     (xbytes & plane_ctl_pkg::TILE_COL_MASK);

  // read port and datapath next values
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd_i;
    if (reg_rd_i) begin
      if (reg_addr_i == plane_ctl_pkg::CTRL_OFFSET) begin
        rdata_next = ctrl_pend_reg;
      end else if (reg_addr_i == plane_ctl_pkg::LINOFF_OFFSET) begin
        rdata_next = lin_pend_reg;
      end else begin
        rdata_next = 32'h00000000;
      end
    end
    addr_next = tiled_o ? surface_base_o + tiled_off :
                surface_base_o + lin_act_reg;
    pvalid_next = pixel_valid_i && plane_on_o;
    rgb_next = pixel_valid_i ? {exp_r, exp_g, exp_b} : rgb_reg;
  end

  // read port and datapath registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      pvalid_reg <= 1'b0;
      rgb_reg <= 30'h00000000;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      addr_reg <= addr_next;
      pvalid_reg <= pvalid_next;
      rgb_reg <= rgb_next;
    end
  end

  AST_IMMEDIATE: assert property (@(posedge clk_i) disable iff (reset_i)
    ctrl_wr && !pipe_enabled_i && !max_fifo_mode_i |=> ctrl_act_reg == $past(reg_wdata_i))
    else $error("idle pipe write not applied at once");
  AST_VBLANK_COPY: assert property (@(posedge clk_i) disable iff (reset_i)
    pipe_enabled_i && armed_reg && vblank_start_i && !max_fifo_mode_i
    |=> ctrl_act_reg == $past(ctrl_pend_reg) && lin_act_reg == $past(lin_pend_reg))
    else $error("armed vblank did not copy pending set");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    pipe_enabled_i && !(armed_reg && vblank_start_i) |=> $stable(ctrl_act_reg))
    else $error("active control changed without armed vblank");
  AST_DEEP_FREEZE: assert property (@(posedge clk_i) disable iff (reset_i)
    max_fifo_mode_i |=> ctrl_act_reg[plane_ctl_pkg::ENABLE_BIT] ==
                        $past(ctrl_act_reg[plane_ctl_pkg::ENABLE_BIT]))
    else $error("enable moved in deep buffer mode");
  AST_FETCH: assert property (@(posedge clk_i) disable iff (reset_i)
    !ctrl_act_reg[plane_ctl_pkg::TRICKLE_BIT] && plane_on_o && buf_free_i |-> fetch_req_o)
    else $error("no fetch with free space");
  AST_FLIP_ROUTE: assert property (@(posedge clk_i) disable iff (reset_i)
    flip_done_blitter_o |-> !flip_done_render_o &&
                           $past(surf_pend_reg[plane_ctl_pkg::FLIP_SRC_BIT]))
    else $error("flip done routed to wrong streamer");
  AST_ASYNC_WAIT: assert property (@(posedge clk_i) disable iff (reset_i)
    surf_state_reg == plane_ctl_pkg::SURF_WAIT_ASYNC && in_vblank_i && !vblank_start_i &&
    pipe_enabled_i |=> $stable(surf_act_reg))
    else $error("async surface applied inside vblank");
  AST_SYNC_APPLY: assert property (@(posedge clk_i) disable iff (reset_i)
    surf_state_reg == plane_ctl_pkg::SURF_WAIT_SYNC && vblank_start_i
    |=> surf_act_reg == $past(surf_pend_reg) && (flip_done_render_o || flip_done_blitter_o))
    else $error("sync surface not applied at vblank");
  AST_READBACK: assert property (@(posedge clk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == plane_ctl_pkg::CTRL_OFFSET
    |=> reg_rvalid_o && reg_rdata_o == $past(ctrl_pend_reg))
    else $error("control read not pending value");
  AST_KEY_WINDOW: assert property (@(posedge clk_i) disable iff (reset_i)
    show_below_o |-> !fmt_alpha_o && (in_overlap_i || !ctrl_act_reg[plane_ctl_pkg::KEY_WIN_BIT]))
    else $error("key applied outside window");

endmodule

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // stimulus, all given a value at time zero
  logic clk_i = 1'h0, reset_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic surf_wr_i = 1'h0, surf_mmio_i = 1'h0, pipe_enabled_i = 1'h0, vblank_start_i = 1'h0;
  logic in_vblank_i = 1'h0, tlb_req_i = 1'h0, max_fifo_mode_i = 1'h0, sprite_enabled_i = 1'h0;
  logic buf_free_i = 1'h0, buf_free_block_i = 1'h0, key_match_i = 1'h0, in_overlap_i = 1'h0;
  logic pixel_valid_i = 1'h0;
  logic [19:0] reg_addr_i = 20'h0;
  logic [31:0] reg_wdata_i = 32'h0, surf_wdata_i = 32'h0, pitch_i = 32'h0;
  logic [11:0] tile_x_i = 12'h0, tile_y_i = 12'h0;
  logic [63:0] pixel_i = 64'h0;
  logic [29:0] palette_rgb_i = 30'h0;
  // observed outputs
  logic [31:0] reg_rdata_o, surface_base_o, first_pixel_addr_o;
  logic pix_valid_o;
  logic [9:0] red_o, green_o, blue_o;
  logic reg_rvalid_o, plane_on_o, blank_o, fetch_req_o, gamma_bypass_o, rotate_o, tiled_o;
  logic use_sprite_space_o, show_below_o, line_double_o, pixel_double_o, fmt_alpha_o;
  logic flip_done_render_o, flip_done_blitter_o;
  logic [3:0] bytes_per_pixel_o;
  // bookkeeping
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] rd_val;

  // indexed, float and reserved flags left open; fmt_alpha_o is connected but no check reads it
  primary_plane_control primary_plane_control_i (
    .clk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .surf_wr_i, .surf_mmio_i, .surf_wdata_i, .pipe_enabled_i, .vblank_start_i,
    .in_vblank_i, .tlb_req_i, .max_fifo_mode_i, .sprite_enabled_i, .buf_free_i,
    .buf_free_block_i, .key_match_i, .in_overlap_i, .tile_x_i, .tile_y_i, .pitch_i,
    .pixel_valid_i, .pixel_i, .palette_rgb_i, .plane_on_o, .blank_o, .fetch_req_o,
    .gamma_bypass_o, .rotate_o, .tiled_o, .use_sprite_space_o, .show_below_o, .line_double_o,
    .pixel_double_o, .fmt_indexed_o(), .fmt_alpha_o, .fmt_float_o(), .fmt_reserved_o(),
    .bytes_per_pixel_o, .surface_base_o, .first_pixel_addr_o, .flip_done_render_o,
    .flip_done_blitter_o, .pix_valid_o, .red_o, .green_o, .blue_o
  );

  // free running 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // compare with four-state equality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs always move 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    tick(1);
    reg_wr_i = 1'h0;
    // idle cycle so a following call never flips the strobe in one step
    tick(1);
  endtask

  // read data is registered and stands in the cycle after the strobe
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    tick(1);
    reg_rd_i = 1'h0;
    check(reg_rvalid_o, 1);
    d = reg_rdata_o;
    tick(1);
  endtask

  task automatic vbl();
    vblank_start_i = 1'h1;
    tick(1);
    vblank_start_i = 1'h0;
  endtask

  task automatic surf(input logic [31:0] d, input logic mmio);
    surf_wdata_i = d;
    surf_mmio_i = mmio;
    surf_wr_i = 1'h1;
    tick(1);
    surf_wr_i = 1'h0;
    tick(1);
  endtask

  // control reset value, reserved bit readback, unmapped read
  task automatic t_regs();
    rd(plane_ctl_pkg::CTRL_OFFSET, rd_val);
    check(rd_val, plane_ctl_pkg::CTRL_RESET);
    wr(plane_ctl_pkg::CTRL_OFFSET, 32'h000B0000);
    wr(plane_ctl_pkg::LINOFF_OFFSET, 32'h12345678);
    rd(plane_ctl_pkg::CTRL_OFFSET, rd_val);
    check(rd_val, 32'h000B0000);
    rd(plane_ctl_pkg::LINOFF_OFFSET, rd_val);
    check(rd_val, 32'h12345678);
    rd(20'h70190, rd_val);
    check(rd_val, 32'h0);
    $display("test regs done");
  endtask

  // pipe off: every multiply code, gamma and tiling apply at once
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      // reserved bits keep what the first control write left there
      wr(plane_ctl_pkg::CTRL_OFFSET, 32'h000B0000 | (32'(m) << 20) | (32'(m & 1) << 10) |
         (32'(m >> 1) << 30));
      tick(1);
      check(line_double_o, m == 1);
      check(pixel_double_o, m == 1 || m == 3);
      check(tiled_o, m & 1);
      check(gamma_bypass_o, (m >> 1) == 0);
    end
    $display("test modes done");
  endtask

  // pipe on: enable waits for vblank, non-trigger writes wait for a trigger
  task automatic t_dbuf();
    wr(plane_ctl_pkg::CTRL_OFFSET, 32'h000B0000);
    tick(1);
    // pipe runs before the plane is enabled
    pipe_enabled_i = 1'h1;
    wr(plane_ctl_pkg::CTRL_OFFSET, 32'h980B0000);
    tick(3);
    check(plane_on_o, 0);
    vbl();
    tick(1);
    check(plane_on_o, 1);
    check(blank_o, 0);
    check(bytes_per_pixel_o, 4);
    buf_free_i = 1'h1;
    tick(1);
    check(fetch_req_o, 1);
    buf_free_i = 1'h0;
    tick(1);
    check(fetch_req_o, 0);
    check(use_sprite_space_o, 1);
    max_fifo_mode_i = 1'h1;
    tick(1);
    check(use_sprite_space_o, 0);
    max_fifo_mode_i = 1'h0;
    // key window, key enable and rotation, no trigger yet
    wr(plane_ctl_pkg::CTRL_OFFSET, 32'h98CB8000);
    vbl();
    tick(1);
    check(rotate_o, 0);
    surf(32'h00ABC008, 1'h0);
    vbl();
    check(flip_done_blitter_o, 1);
    check(surface_base_o, 32'h00ABC000);
    tick(1);
    check(flip_done_blitter_o, 0);
    check(rotate_o, 1);
    key_match_i = 1'h1;
    tick(1);
    check(show_below_o, 0);
    in_overlap_i = 1'h1;
    tick(1);
    check(show_below_o, 1);
    key_match_i = 1'h0;
    in_overlap_i = 1'h0;
    $display("test double buffer done");
  endtask

  // async mmio surface write waits for a lookup request outside vblank
  task automatic t_async();
    wr(plane_ctl_pkg::CTRL_OFFSET, 32'h980B0200);
    // no command stream update once async is written
    surf(32'h00ABC000, 1'h1);
    vbl();
    tick(1);
    // one async update after vblank, multiply off
    surf(32'h00DEF000, 1'h1);
    in_vblank_i = 1'h1;
    tlb_req_i = 1'h1;
    tick(1);
    check(surface_base_o, 32'h00ABC000);
    in_vblank_i = 1'h0;
    tick(1);
    tlb_req_i = 1'h0;
    check(flip_done_render_o, 1);
    check(surface_base_o, 32'h00DEF000);
    $display("test async done");
  endtask

  // widened pixel and linear first pixel address from the active copy
  task automatic t_pixel();
    pixel_i = 64'h0000000000FF00FF;
    pixel_valid_i = 1'h1;
    tick(1);
    pixel_valid_i = 1'h0;
    check(pix_valid_o, 1);
    check(red_o, 10'h3FF);
    check(green_o, 10'h000);
    check(blue_o, 10'h3FF);
    check(first_pixel_addr_o, 32'h13134678);
    $display("test pixel done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // the whole sequence takes about 60 cycles; allow far more
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    tick(3);
    reset_i = 1'h0;
    t_regs();
    t_modes();
    t_dbuf();
    t_async();
    t_pixel();
    tally_and_finish();
  end
endmodule
